// ===== pkg/sync_serial_port_defs.svh
// Purpose: Constants for the synchronous serial port.
// Assumes: 10 MHz system clock.
// Notes: Offsets are not used; the block has no software registers.
`ifndef SYNC_SERIAL_PORT_DEFS_SVH
`define SYNC_SERIAL_PORT_DEFS_SVH
`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_AW 3
`define SSP_SIZE_MIN 4'h3
`define SSP_SIZE_RST 4'h7
`define SSP_PRESCALE_RST 8'h02
`define SSP_DIV_RST 8'h00
`endif

// ===== pkg/sync_serial_port_pkg.sv
// Purpose: Types shared by the synchronous serial port.
// Assumes: Nothing beyond the constants header.
// Notes: Frame formats are selected by a two-bit field.
`default_nettype none
package sync_serial_port_pkg;
  typedef enum logic [1:0] {
    FMT_SPI = 2'h0,
    FMT_SYNC = 2'h1,
    FMT_WIRE = 2'h2
  } frame_fmt_t;

  typedef struct packed {
    logic enable;
    logic master;
    logic slaveOutDisable;
    frame_fmt_t format;
    logic [3:0] sizeMinus1;
    logic clkPol;
    logic clkPha;
    logic [7:0] prescale;
    logic [7:0] divider;
  } port_cfg_t;

  typedef struct packed {
    logic txEmpty;
    logic txFull;
    logic rxEmpty;
    logic rxFull;
    logic busy;
  } port_status_t;
endpackage
`default_nettype wire

// ===== verilog/sync_serial_port.sv
// Purpose: Synchronous serial port with transmit and receive queues.
// Assumes: All inputs synchronous to sys_clk; configuration held stable while busy.
// Notes: SPI format mode 0/1/2/3; the other two formats reuse the same shifter
//        with frame select pulsed for half a bit period (sync) or held low (wire).
`default_nettype none
`include "sync_serial_port_defs.svh"

module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign empty = !outValid;
  assign full = !inReady;

  always_comb begin
    wrPtr_d = push ? wrPtr_q + AW'(1) : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + AW'(1) : rdPtr_q;
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule

// Summary of operation
// RULE1: The port drives a four-signal full-duplex link of clock, frame select, data out and data in.
// RULE2: Queued parallel words are shifted out serially and received bits are assembled into words.
// RULE3: The frame length is configurable from four to sixteen bits inclusive.
// RULE4: Separate eight-word, 16-bit transmit and receive queues operate independently; the code starts no transfer while the receive queue is full.
// RULE5: One of three frame formats, SPI among them, is selected by configuration.
// RULE6: The port acts as master driving clock and frame, or as slave following them.
// RULE7: A slave may be configured to leave its data output undriven.
// RULE8: The master serial clock comes from a prescaler followed by a bit-rate divider.
// RULE9: The user must pick a bit rate that the attached peripheral accepts.
// RULE10: Empty and full status is reported for both queues.
module sync_serial_port (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire sync_serial_port_pkg::port_cfg_t cfg,
  input wire logic [15:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [15:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output sync_serial_port_pkg::port_status_t status,
  output logic sclkOut,
  output logic sclkOe,
  input wire logic sclkIn,
  output logic frameOut,
  output logic frameOe,
  input wire logic frameIn,
  output logic dataOut,
  output logic dataOe,
  input wire logic dataIn
);
  typedef enum logic [1:0] {IDLE, LEAD, SHIFT} shift_state_t;

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  logic [15:0] txHead, rxWord;
  logic txHeadValid, txPop, rxPush, rxInReady;
  logic txEmpty, txFull, rxEmpty, rxFull, rxOutValid;
  logic [15:0] rxOutData;

  ssp_fifo #(.WIDTH(`SSP_WORD_W), .DEPTH(`SSP_FIFO_DEPTH)) txQueue ( // RULE4
    .sys_clk(sys_clk), .nrst(nrst),
    .inData(txData), .inValid(txValid), .inReady(txReady),
    .outData(txHead), .outValid(txHeadValid), .outReady(txPop),
    .empty(txEmpty), .full(txFull)
  );

  ssp_fifo #(.WIDTH(`SSP_WORD_W), .DEPTH(`SSP_FIFO_DEPTH)) rxQueue ( // RULE4
    .sys_clk(sys_clk), .nrst(nrst),
    .inData(rxWord), .inValid(rxPush), .inReady(rxInReady),
    .outData(rxOutData), .outValid(rxOutValid), .outReady(rxReady),
    .empty(rxEmpty), .full(rxFull)
  );

  assign rxData = rxOutData;
  assign rxValid = rxOutValid;

  // ----------------------------------------------------------------
  // Bit clock generation
  // ----------------------------------------------------------------
  logic [7:0] preCnt_q, preCnt_d, divCnt_q, divCnt_d;
  logic halfTick;

  always_comb begin
    preCnt_d = preCnt_q + 8'h01;
    divCnt_d = divCnt_q;
    halfTick = 1'b0;
    if (preCnt_q >= cfg.prescale) begin // RULE8
      preCnt_d = 8'h00;
      divCnt_d = divCnt_q + 8'h01;
      if (divCnt_q >= cfg.divider) begin // RULE8
        divCnt_d = 8'h00;
        halfTick = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      preCnt_q <= 8'h00;
      divCnt_q <= 8'h00;
    end else begin
      preCnt_q <= preCnt_d;
      divCnt_q <= divCnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Slave edge detection on the incoming clock; frame select level decode
  // ----------------------------------------------------------------
  logic sclkPrev_q, slvSel;
  logic slvRise, slvFall;
  assign slvRise = sclkIn && !sclkPrev_q;
  assign slvFall = !sclkIn && sclkPrev_q;
  assign slvSel = (cfg.format == sync_serial_port_pkg::FMT_SYNC) ? frameIn : !frameIn;

  always_ff @(posedge sys_clk) begin
    // Following the pin through reset avoids a false edge when the clock idles high.
    sclkPrev_q <= sclkIn;
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  shift_state_t state_q, state_d;
  logic [15:0] txSh_q, txSh_d, rxSh_q, rxSh_d;
  logic [3:0] bitCnt_q, bitCnt_d, size;
  logic sclk_q, sclk_d, frame_q, frame_d, dout_q, dout_d;
  logic sampleEdge, launchEdge, edgeNow, lastBit;

  assign size = (cfg.sizeMinus1 < `SSP_SIZE_MIN) ? `SSP_SIZE_MIN : cfg.sizeMinus1; // RULE3
  assign lastBit = (bitCnt_q == size);

  always_comb begin
    if (cfg.master) begin // RULE6
      edgeNow = halfTick;
      sampleEdge = halfTick && (sclk_q == (cfg.clkPol ^ cfg.clkPha));
      launchEdge = halfTick && !sampleEdge;
    end else begin
      edgeNow = slvRise || slvFall;
      sampleEdge = (slvRise && !(cfg.clkPol ^ cfg.clkPha)) ||
                   (slvFall && (cfg.clkPol ^ cfg.clkPha));
      launchEdge = edgeNow && !sampleEdge;
    end
  end

  always_comb begin
    state_d = state_q;
    txSh_d = txSh_q;
    rxSh_d = rxSh_q;
    bitCnt_d = bitCnt_q;
    sclk_d = sclk_q;
    frame_d = frame_q;
    dout_d = dout_q;
    txPop = 1'b0;
    rxPush = 1'b0;
    rxWord = rxSh_q;
    unique case (state_q)
      IDLE: begin
        sclk_d = cfg.clkPol;
        frame_d = (cfg.format == sync_serial_port_pkg::FMT_SYNC) ? 1'b0 : 1'b1;
        bitCnt_d = 4'h0;
        if (cfg.enable && txHeadValid && rxInReady &&
            (cfg.master ? halfTick : slvSel)) begin
          txPop = 1'b1; // RULE2
          txSh_d = txHead << (4'hF - size);
          rxSh_d = 16'h0000;
          dout_d = txHead[size];
          state_d = LEAD;
          frame_d = (cfg.format == sync_serial_port_pkg::FMT_SYNC); // RULE5
        end
      end
      LEAD: begin
        if (cfg.master && halfTick) begin
          state_d = SHIFT;
          if (cfg.format == sync_serial_port_pkg::FMT_SYNC) begin
            frame_d = 1'b0;
          end
        end else if (!cfg.master) begin
          state_d = SHIFT;
        end
      end
      SHIFT: begin
        if (cfg.master && edgeNow) begin
          sclk_d = !sclk_q; // RULE1
        end
        if (sampleEdge) begin
          rxSh_d = {rxSh_q[14:0], dataIn}; // RULE2
          if (lastBit) begin
            rxPush = 1'b1;
            rxWord = {rxSh_q[14:0], dataIn};
            state_d = IDLE;
          end
        end
        if (launchEdge) begin
          txSh_d = {txSh_q[14:0], 1'b0};
          // With the late phase the first launch must still show the top bit.
          dout_d = cfg.clkPha ? txSh_q[15] : txSh_d[15];
        end
        if (sampleEdge) begin
          bitCnt_d = bitCnt_q + 4'h1;
        end
        if (!cfg.master && !slvSel && cfg.format != sync_serial_port_pkg::FMT_SYNC) begin
          state_d = IDLE;
        end
      end
      default: state_d = IDLE;
    endcase
    if (!cfg.enable) begin
      state_d = IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= IDLE;
      txSh_q <= 16'h0000;
      rxSh_q <= 16'h0000;
      bitCnt_q <= 4'h0;
      sclk_q <= 1'b0;
      frame_q <= 1'b1;
      dout_q <= 1'b0;
    end else begin
      state_q <= state_d;
      txSh_q <= txSh_d;
      rxSh_q <= rxSh_d;
      bitCnt_q <= bitCnt_d;
      sclk_q <= sclk_d;
      frame_q <= frame_d;
      dout_q <= dout_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and status
  // ----------------------------------------------------------------
  logic dataOe_q, ctlOe_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dataOe_q <= 1'b0;
      ctlOe_q <= 1'b0;
      status <= '0;
    end else begin
      ctlOe_q <= cfg.enable && cfg.master; // RULE6
      dataOe_q <= cfg.enable && (cfg.master || (!cfg.slaveOutDisable && slvSel)); // RULE7
      status <= '{txEmpty: txEmpty, txFull: txFull, rxEmpty: rxEmpty,
                  rxFull: rxFull, busy: (state_q != IDLE)}; // RULE10
    end
  end

  assign sclkOut = sclk_q;
  assign frameOut = frame_q;
  assign dataOut = dout_q;
  assign sclkOe = ctlOe_q;
  assign frameOe = ctlOe_q;
  assign dataOe = dataOe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rule10;
    @(posedge sys_clk) disable iff (!nrst)
      $past(nrst) |-> (status.txEmpty == $past(txEmpty)) && (status.rxFull == $past(rxFull));
  endproperty
  a_rule10: assert property (p_rule10) else $error("tx empty status wrong"); // RULE10

  property p_rule7;
    @(posedge sys_clk) disable iff (!nrst)
      (!cfg.master && cfg.slaveOutDisable) |=> !dataOe;
  endproperty
  a_rule7: assert property (p_rule7) else $error("slave drove data"); // RULE7

  property p_rule6;
    @(posedge sys_clk) disable iff (!nrst) !cfg.master |=> !sclkOe && !frameOe;
  endproperty
  a_rule6: assert property (p_rule6) else $error("slave drove clock"); // RULE6

  property p_rule8;
    @(posedge sys_clk) disable iff (!nrst) halfTick |-> preCnt_q >= cfg.prescale;
  endproperty
  a_rule8: assert property (p_rule8) else $error("tick without prescale"); // RULE8

  property p_rule3;
    @(posedge sys_clk) disable iff (!nrst) size >= `SSP_SIZE_MIN;
  endproperty
  a_rule3: assert property (p_rule3) else $error("frame under four bits"); // RULE3

  property p_rule4;
    @(posedge sys_clk) disable iff (!nrst) txFull |-> !txReady;
  endproperty
  a_rule4: assert property (p_rule4) else $error("tx queue accepts when full"); // RULE4

  property p_rule2;
    @(posedge sys_clk) disable iff (!nrst) txPop |=> state_q == LEAD;
  endproperty
  a_rule2: assert property (p_rule2) else $error("pop without frame"); // RULE2

  property p_rule1;
    @(posedge sys_clk) disable iff (!nrst) (state_q == IDLE && cfg.master) |=> sclkOut == $past(cfg.clkPol);
  endproperty
  a_rule1: assert property (p_rule1) else $error("idle clock level wrong"); // RULE1

  property p_rule5;
    @(posedge sys_clk) disable iff (!nrst)
      (state_q == IDLE && cfg.format == sync_serial_port_pkg::FMT_SPI && !txPop) |=> frameOut;
  endproperty
  a_rule5: assert property (p_rule5) else $error("spi frame active in idle"); // RULE5
endmodule
`default_nettype wire

// ===== verif/serial_peer_model.sv
// Purpose: Behavioural serial peripheral that answers the port in clock mode 0 or 3.
// Assumes: Clock mode 0 or 3; both sides sample on the rising clock edge.
// Notes: Reply words follow a fixed sequence so that the bench can predict them.
`default_nettype none
module serial_peer_model (
  input wire logic sclk,
  input wire logic frameN,
  input wire logic mosi,
  input wire logic [4:0] nBits,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got [64];
  logic [15:0] sh = 16'h0000;
  int n = 0;
  int cnt = 0;
  function automatic logic [15:0] reply(input int k);
    return 16'hA5C3 ^ (16'(k) * 16'h1357);
  endfunction
  task automatic load();
    logic [15:0] r;
    r = reply(n);
    if (cnt < nBits) miso = r[nBits - 1 - cnt];
  endtask
  // ---------------------------------------------------------------
  // Shifting
  // ---------------------------------------------------------------
  initial miso = 1'b0;
  always @(negedge frameN) begin
    cnt = 0;
    sh = 16'h0000;
    load();
  end
  // A released line must not keep its last level, or a late sample would pass by luck.
  always @(posedge frameN) miso = ~miso;
  always @(negedge sclk) if (!frameN) load();
  always @(posedge sclk) begin
    if (!frameN) begin
      sh = {sh[14:0], mosi};
      cnt++;
      if (cnt == nBits) begin
        got[n] = sh;
        n++;
        cnt = 0;
        sh = 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/sync_serial_port_tb_top.sv
// Purpose: Self-checking bench for the synchronous serial port in master and slave roles.
// Assumes: The peer model answers in clock mode 0 or 3.
// Notes: Expected replies are recomputed here from the peer's fixed sequence.
`default_nettype none
`include "sync_serial_port_defs.svh"
module sync_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  sync_serial_port_pkg::port_cfg_t cfg = '0;
  logic [15:0] txData = 16'h0000;
  logic txValid = 1'b0;
  logic rxReady = 1'b0;
  logic sclkIn = 1'b0;
  logic frameIn = 1'b1;
  logic [15:0] rxData;
  logic txReady, rxValid, sclkOut, sclkOe, frameOut, frameOe, dataOut, dataOe, miso;
  sync_serial_port_pkg::port_status_t status;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'hb5e6192a;
  int cyc = 0;
  int lastRise = 0;
  int period = 0;
  logic sclkPrev = 1'b0;
  logic [15:0] sent [64];
  logic [15:0] w;
  logic ok;
  int i, k, sz, base, nx;
  initial forever #50 sys_clk = ~sys_clk;
  sync_serial_port i_sync_serial_port (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .status(status), .sclkOut(sclkOut),
    .sclkOe(sclkOe), .sclkIn(sclkIn), .frameOut(frameOut), .frameOe(frameOe),
    .frameIn(frameIn), .dataOut(dataOut), .dataOe(dataOe), .dataIn(miso));
  serial_peer_model i_serial_peer_model (.sclk(sclkOut), .frameN(frameOut), .mosi(dataOut),
    .nBits(5'(cfg.sizeMinus1) + 5'h01), .miso(miso));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sclkPrev <= sclkOut;
    if (sclkOut && !sclkPrev) begin
      period <= cyc - lastRise;
      lastRise <= cyc;
    end
  end
  function automatic logic [15:0] reply(input int j);
    return 16'hA5C3 ^ (16'(j) * 16'h1357);
  endfunction
  function automatic logic [15:0] mask(input logic [15:0] v, input int b);
    return v & 16'((17'h00001 << b) - 17'h00001);
  endfunction
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fail_wait(input string what);
    n_errors++;
    $display("ERROR %s expected done seen timeout", what);
    test_done();
  endtask
  task automatic push(input logic [15:0] d, input int lim, output logic acc);
    int j;
    @(posedge sys_clk);
    txData <= d;
    txValid <= 1'b1;
    @(negedge sys_clk);
    for (j = 0; j < lim && txReady !== 1'b1; j++) @(negedge sys_clk);
    acc = (txReady === 1'b1);
    @(posedge sys_clk);
    txValid <= 1'b0;
  endtask
  task automatic pop(output logic [15:0] d);
    int j;
    @(posedge sys_clk);
    rxReady <= 1'b1;
    @(negedge sys_clk);
    for (j = 0; j < 3000 && rxValid !== 1'b1; j++) @(negedge sys_clk);
    if (rxValid !== 1'b1) fail_wait("rxValid");
    d = rxData;
    @(posedge sys_clk);
    rxReady <= 1'b0;
  endtask
  task automatic idle();
    int j;
    repeat (2) @(negedge sys_clk);
    for (j = 0; j < 2000 && status.busy !== 1'b0; j++) @(negedge sys_clk);
    if (status.busy !== 1'b0) fail_wait("busy");
  endtask
  task automatic drain(input int cnt);
    int b;
    b = cfg.sizeMinus1 + 1;
    for (int j = 0; j < cnt; j++) begin
      pop(w);
      check("rxData", mask(reply(base), b), w);
      check("peerWord", mask(sent[base], b), i_serial_peer_model.got[base]);
      base++;
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    base = 0;
    cfg.master = 1'b1;
    cfg.sizeMinus1 = 4'h7;
    cfg.divider = 8'h01;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check("sclkOe", 16'h0000, 16'(sclkOe));
    check("frameOut", 16'h0001, 16'(frameOut));
    check("txEmpty", 16'h0001, 16'(status.txEmpty));
    check("rxEmpty", 16'h0001, 16'(status.rxEmpty));
    // The port stays disabled so that the transmit queue can only fill up.
    for (i = 0; i < 9; i++) begin
      sent[i] = 16'($random(seed));
      push(sent[i], 4, ok);
      check("txAccepted", 16'(i < `SSP_FIFO_DEPTH), 16'(ok));
    end
    nx = `SSP_FIFO_DEPTH;
    repeat (2) @(negedge sys_clk);
    check("txFull", 16'h0001, 16'(status.txFull));
    @(posedge sys_clk);
    cfg.enable <= 1'b1;
    for (i = 0; i < 5000 && status.rxFull !== 1'b1; i++) @(negedge sys_clk);
    check("rxFull", 16'h0001, 16'(status.rxFull));
    check("txEmptyFull", 16'h0001, 16'(status.txEmpty));
    drain(`SSP_FIFO_DEPTH);
    repeat (2) @(negedge sys_clk);
    check("rxEmptyAfter", 16'h0001, 16'(status.rxEmpty));
    for (k = 0; k < 4; k++) begin
      sz = (k == 0) ? 4 : (k == 1) ? 16 : 5 + ($unsigned($random(seed)) % 11);
      idle();
      @(posedge sys_clk);
      cfg.sizeMinus1 <= 4'(sz - 1);
      cfg.prescale <= 8'(k);
      cfg.clkPol <= (k == 3);
      cfg.clkPha <= (k == 3);
      cfg.divider <= 8'(k % 2 + 1);
      for (i = 0; i < 2; i++) begin
        sent[nx] = 16'($random(seed));
        push(sent[nx], 50, ok);
        check("txAccepted", 16'h0001, 16'(ok));
        nx++;
      end
      drain(2);
      check("sclkPeriod", 16'(2 * (k + 1) * (k % 2 + 2)), 16'(period));
    end
    idle();
    @(posedge sys_clk);
    cfg.master <= 1'b0;
    cfg.slaveOutDisable <= 1'b1;
    frameIn <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("dataOeOff", 16'h0000, 16'(dataOe));
    check("sclkOeSlave", 16'h0000, 16'(sclkOe));
    @(posedge sys_clk);
    cfg.slaveOutDisable <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("dataOeOn", 16'h0001, 16'(dataOe));
    @(posedge sys_clk);
    frameIn <= 1'b1;
    cfg.master <= 1'b1;
    for (k = 1; k < 3; k++) begin
      idle();
      @(posedge sys_clk);
      cfg.format <= sync_serial_port_pkg::frame_fmt_t'(k);
      push(16'($random(seed)), 50, ok);
      for (i = 0; i < 500 && !(frameOe === 1'b1 && frameOut === (k == 1)); i++)
        @(negedge sys_clk);
      check("frameActive", 16'(k == 1), 16'(frameOut));
      pop(w);
    end
    test_done();
  end
endmodule
`default_nettype wire
